// [common/iec_params.svh]
// Purpose: constants of the interval event counter
// Assumes: register index times four is the byte address
// Notes: included by the bench and the design files
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH

// register indices
`define IEC_IDX_PORT0_DIR 16'hff20
`define IEC_IDX_ROUTE 16'hff39
`define IEC_IDX_COUNT 16'hff10
`define IEC_IDX_CMP0 16'hff12
`define IEC_IDX_CMP1 16'hff14
`define IEC_IDX_MODE 16'hff16
`define IEC_IDX_PRESC 16'hff17
`define IEC_IDX_OUTCTL 16'hff18
`define IEC_IDX_PORT0_LATCH 16'hff00

// reset values
`define IEC_RST_PORT0_DIR 8'hff
`define IEC_RST_ROUTE 8'h00
`define IEC_RST_BYTE 8'h00
`define IEC_RST_COUNT 16'h0000

// timer mode register: mode select hi/lo
`define IEC_MODE_HI 3
`define IEC_MODE_LO 2
`define IEC_MODE_STOP 2'h0
`define IEC_MODE_PIN_CLEAR 2'h2
`define IEC_MODE_MATCH_CLEAR 2'h3

// prescaler register
`define IEC_CKS_HI 1
`define IEC_CKS_LO 0
`define IEC_ES0_HI 5
`define IEC_ES0_LO 4
`define IEC_CKS_FULL 2'h0
`define IEC_CKS_DIV4 2'h1
`define IEC_CKS_DIV256 2'h2
`define IEC_CKS_EVENT 2'h3
`define IEC_DIV4_BIT 1
`define IEC_DIV256_BIT 7
`define IEC_DIV_W 8

// edge select codes
`define IEC_EDGE_FALL 2'h0
`define IEC_EDGE_RISE 2'h1
`define IEC_EDGE_BOTH 2'h3

// output control register
`define IEC_OC_ENABLE 0
`define IEC_OC_INV0 1
`define IEC_OC_CLR 2
`define IEC_OC_SET 3
`define IEC_OC_INV1 4

// pin routing select
`define IEC_RT_HI 5
`define IEC_RT_LO 4
`define IEC_RT_NONE 2'h0
`define IEC_RT_PIN_A 2'h1
`define IEC_RT_PIN_B 2'h2

// port pin that carries the timer output
`define IEC_TOUT_PIN 1

`endif

// [common/iec_pkg.sv]
// Purpose: types of the interval event counter
// Assumes: nothing
// Notes: constants live in iec_params.svh
package iec_pkg;
    typedef logic [15:0] iec_count_t;
    typedef logic [7:0] iec_byte_t;
    typedef enum logic [3:0] {
        IEC_R_NONE,
        IEC_R_COUNT,
        IEC_R_CMP0,
        IEC_R_CMP1,
        IEC_R_MODE,
        IEC_R_PRESC,
        IEC_R_OUTCTL,
        IEC_R_ROUTE,
        IEC_R_DIR,
        IEC_R_LATCH
    } iec_reg_e;
endpackage

// [dv/iec_pin_model.sv]
// Purpose: event source on the two routed pins
// Assumes: pins sampled on clock
// Notes: the pin not carrying events shows noise when enabled
`timescale 1ns/1ps
`default_nettype none
module iec_pin_model (
    input wire logic clock,
    output logic pin_a,
    output logic pin_b
);
    int sel = 1;
    bit noise = 1'b0;
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    ////////////////////////////////////////
    always @(posedge clock) begin
        if (noise && sel != 1) pin_a <= $urandom;
        if (noise && sel != 2) pin_b <= $urandom;
    end
    task automatic drive(input logic v);
        @(posedge clock);
        if (sel == 2) pin_b <= v;
        else pin_a <= v;
    endtask
    task automatic idle();
        @(posedge clock);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
    endtask
    // each event follows a one-sample spike that must be ignored
    task automatic pulse(input int n);
        repeat (n) begin
            drive(1'b1);
            drive(1'b0);
            drive(1'b1);
            repeat (3) @(posedge clock);
            drive(1'b0);
            repeat (4) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// [dv/iec_top_sva.sv]
// Purpose: port checks of the interval event counter
// Assumes: bound to iec_top, one clock domain
// Notes: sees only top ports
`timescale 1ns/1ps
`default_nettype none
module iec_top_sva (
    input wire logic clock,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] port0_out,
    input wire logic [7:0] port0_oe,
    input wire logic timer_output_pin,
    input wire logic match_irq_zero,
    input wire logic match_irq_one
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    a_irq0_pulse: assert property (match_irq_zero |=> !match_irq_zero)
        else $error("match zero longer than one cycle");
    a_irq1_pulse: assert property (match_irq_one |=> !match_irq_one)
        else $error("match one longer than one cycle");
    a_wait_cause: assert property
        (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_wait_answer: assert property
        ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_read_upper: assert property
        (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_reset_quiet: assert property ($fell(reset) |->
        port0_oe == 8'h00 && !timer_output_pin && !match_irq_zero)
        else $error("outputs not quiet after reset");
    a_tout_port: assert property
        (timer_output_pin && $past(timer_output_pin) |-> port0_out[1])
        else $error("timer output missing on port pin");
    c_irq0: cover property (match_irq_zero);
    c_irq1: cover property (match_irq_one);
    c_toggle: cover property ($changed(timer_output_pin));
endmodule
bind iec_top iec_top_sva u_sva (.clock(clock), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port0_out(port0_out), .port0_oe(port0_oe),
    .timer_output_pin(timer_output_pin),
    .match_irq_zero(match_irq_zero), .match_irq_one(match_irq_one));
`default_nettype wire

// [dv/iec_top_tb.sv]
// Purpose: self-checking bench of the interval event counter
// Assumes: the master waits up to 50 cycles for waitrequest low
// Notes: register and pin checks are made at the falling edge, where outputs are settled
`include "iec_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iec_top_tb
    import iec_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [17:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_output_pin, match_irq_zero, match_irq_one;
    logic pin_a, pin_b, tout_q;
    logic [7:0] port0_out, port0_oe;
    logic [31:0] q;
    int error_cnt = 0, total_checks = 0, cyc = 0, last0, last1, gap = 0;
    int n0 = 0, n1 = 0, ntg = 0, m, b, t;
    initial forever #10 clock = ~clock;
    iec_top DUT (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .alt_pin_a(pin_a), .alt_pin_b(pin_b), .port0_out(port0_out),
        .port0_oe(port0_oe), .timer_output_pin(timer_output_pin),
        .match_irq_zero(match_irq_zero), .match_irq_one(match_irq_one));
    iec_pin_model src (.clock(clock), .pin_a(pin_a), .pin_b(pin_b));
    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_reg(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_int(input string s, input int e, g);
        total_checks++;
        if (g != e) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", s, e, g);
        end
    endtask
    // model of the match spacing, checked at each pulse after the first while gap is set
    always @(posedge clock) begin
        cyc++;
        if (gap == 0) last0 = -1;
        if (gap == 0) last1 = -1;
        if (match_irq_zero === 1'b1) begin
            n0++;
            if (last0 >= 0) chk_int("irq0 gap", gap, cyc - last0);
            last0 = cyc;
        end
        if (match_irq_one === 1'b1) begin
            n1++;
            if (last1 >= 0) chk_int("irq1 gap", gap, cyc - last1);
            last1 = cyc;
        end
        if (timer_output_pin !== tout_q) ntg++;
        tout_q = timer_output_pin;
    end
    task automatic bus(input logic w, input logic [15:0] idx,
        input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            test_done();
        end
        // taken at the edge that sees waitrequest low, then released
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clock);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask
    task automatic wait_n0(input int n);
        int i;
        for (i = 0; i < 2000 && n0 < n; i++) @(negedge clock);
        if (n0 < n) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic ev(input int n);
        src.pulse(n);
        @(negedge clock);
    endtask
    initial begin
        void'($urandom(22598));
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk_reg("oe", 32'h0, {24'h0, port0_oe});
        bus(1'b0, `IEC_IDX_PORT0_DIR, 0, q);
        chk_reg("dir", 32'hff, q);
        bus(1'b0, `IEC_IDX_ROUTE, 0, q);
        chk_reg("route", 32'h0, q);
        wr(16'hff30, 32'h5a);
        bus(1'b0, 16'hff30, 0, q);
        chk_reg("unmapped", 32'h0, q);
        wr(`IEC_IDX_PORT0_DIR, 32'hfc);
        wr(`IEC_IDX_PORT0_LATCH, 32'h0);
        chk_reg("oe", 32'h3, {24'h0, port0_oe});
        m = $urandom_range(20, 3);
        wr(`IEC_IDX_CMP0, m);
        wr(`IEC_IDX_CMP1, m - 1);
        wr(`IEC_IDX_OUTCTL, 32'h3);
        wr(`IEC_IDX_MODE, 32'hc);
        b = n0;
        t = ntg;
        wait_n0(b + 1);
        gap = m + 1;
        wait_n0(b + 5);
        bus(1'b0, `IEC_IDX_COUNT, 0, q);
        chk_int("count in range", 1, int'(q <= m));
        chk_int("toggles", n0 - b, ntg - t);
        wr(`IEC_IDX_MODE, 32'h0);
        gap = 0;
        // a match launched by the stopping edge is still counted
        @(negedge clock);
        b = n0;
        repeat (3 * m) @(negedge clock);
        chk_int("stopped irqs", b, n0);
        bus(1'b0, `IEC_IDX_COUNT, 0, q);
        chk_reg("stopped count", 32'h0, q);
        wr(`IEC_IDX_OUTCTL, 32'h2);
        wr(`IEC_IDX_MODE, 32'hc);
        wait_n0(b + 2);
        chk_reg("tout off", 32'h0, {31'h0, timer_output_pin});
        wr(`IEC_IDX_OUTCTL, 32'h1);
        wr(`IEC_IDX_OUTCTL, 32'h9);
        chk_reg("tout set", 32'h1, {31'h0, timer_output_pin});
        @(negedge clock);
        chk_reg("pin one", 32'h2, {24'h0, port0_out});
        bus(1'b0, `IEC_IDX_OUTCTL, 0, q);
        chk_reg("outctl", 32'h1, q);
        for (int r = 0; r < 3; r++) begin
            src.noise = 1'b0;
            src.idle();
            wr(`IEC_IDX_MODE, 32'h0);
            wr(`IEC_IDX_PRESC, 32'h13);
            wr(`IEC_IDX_ROUTE, r << 4);
            src.sel = (r == 2) ? 2 : 1;
            wr(`IEC_IDX_MODE, 32'hc);
            src.noise = 1'b1;
            b = n0;
            ev(m + 1);
            chk_int("events", b, n0);
            ev(1);
            chk_int("events", b + (r > 0), n0);
            ev(m);
            chk_int("events", b + (r > 0), n0);
            ev(1);
            chk_int("events", b + 2 * (r > 0), n0);
        end
        test_done();
    end
endmodule
`default_nettype wire

// [hdl/iec_edge_filter.sv]
// Purpose: noise filter and valid edge detector for the event input
// Assumes: pin is synchronous to clock
// Notes: a new level is accepted after two equal samples in a row
`include "iec_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iec_edge_filter (
    input wire logic clock,
    input wire logic reset,
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    output logic edge_pulse
);
    logic samp_r;
    logic lvl_r;
    logic edge_r;
    logic accept;

    assign accept = (pin == samp_r) && (pin != lvl_r); // R11
    assign edge_pulse = edge_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            samp_r <= 1'b0;
        end else begin
            samp_r <= pin; // R11
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lvl_r <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            if (accept) begin
                lvl_r <= pin;
            end
            unique case (edge_sel)
                `IEC_EDGE_FALL: edge_r <= accept && !pin;
                `IEC_EDGE_RISE: edge_r <= accept && pin;
                `IEC_EDGE_BOTH: edge_r <= accept;
                default: edge_r <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [hdl/iec_top.sv]
// Purpose: 16-bit interval timer, square wave and event counter
// Assumes: Avalon-MM slave, byte address, one wait cycle per access
// Notes: capture and pin-clear operation are not provided
`include "iec_params.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// How it works
// R01 - mode select 11 starts counting on the chosen count clock.
// R02 - counter equal to compare zero clears counter, raises match zero.
// R03 - compare zero M gives M+1 count clocks between match interrupts.
// R04 - software never loads compare zero with zero in these modes.
// R05 - match one is raised on compare one equality even if unused.
// R06 - output control 03h makes timer output toggle on compare zero.
// R07 - toggle, clear and interrupt all come from one match event.
// R08 - clock select 11 counts valid edges of event input zero.
// R09 - software avoids event counting while mode select is 10.
// R10 - first match after M+2 events, later ones after M+1.
// R11 - event input accepted only after two equal consecutive samples.
// R12 - reading the counter returns the count and does not disturb it.
// R13 - routing field picks none, pin a or pin b; 11 is prohibited.
// R14 - direction bit 0 turns output buffer on, 1 makes pin an input.
// R15 - reset loads port-0 direction with ffh, all pins inputs.
// R16 - timer output on pin one needs direction and latch bits zero.
// R17 - pins used as timer inputs need their direction bits set.
// R18 - prescaler is not rewritten while mode select is not 00.
// R19 - output enable 0 holds timer output low, 1 lets toggling drive.
// R20 - counter is 16 bits and wraps from ffffh to 0000h.
// R21 - mode select 00 stops, clears counter and suppresses matches.
module iec_top
    import iec_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic alt_pin_a,
    input wire logic alt_pin_b,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe,
    output logic timer_output_pin,
    output logic match_irq_zero,
    output logic match_irq_one
);
    ////////////////////////////////////////////////////////////////////
    // registers
    iec_count_t up_counter_r;
    iec_count_t compare_reg_zero_r;
    iec_count_t compare_reg_one_r;
    iec_byte_t timer_mode_register_r;
    iec_byte_t prescaler_register_r;
    iec_byte_t output_control_register_r;
    iec_byte_t pin_routing_select_r;
    iec_byte_t port0_direction_r;
    iec_byte_t port0_latch_r;
    logic tout_r;
    logic started_r;
    logic irq0_r;
    logic irq1_r;
    logic [`IEC_DIV_W-1:0] div_r;
    logic wait_r;
    logic [31:0] rdata_r;
    iec_byte_t p0_out_r;
    iec_byte_t p0_oe_r;

    logic [1:0] mode_sel;
    logic [1:0] clk_sel;
    logic [1:0] route_sel;
    logic event_in;
    logic event_edge;
    logic tick;
    logic running;
    logic match0;
    logic match1;
    logic req;
    logic wr_go;
    iec_reg_e sel;

    ////////////////////////////////////////////////////////////////////
    // address decode
    function automatic iec_reg_e reg_decode(input logic [ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = a[17:2];
        if (a[1:0] != 2'h0) begin
            reg_decode = IEC_R_NONE;
        end else begin
            unique case (idx)
                `IEC_IDX_COUNT: reg_decode = IEC_R_COUNT;
                `IEC_IDX_CMP0: reg_decode = IEC_R_CMP0;
                `IEC_IDX_CMP1: reg_decode = IEC_R_CMP1;
                `IEC_IDX_MODE: reg_decode = IEC_R_MODE;
                `IEC_IDX_PRESC: reg_decode = IEC_R_PRESC;
                `IEC_IDX_OUTCTL: reg_decode = IEC_R_OUTCTL;
                `IEC_IDX_ROUTE: reg_decode = IEC_R_ROUTE;
                `IEC_IDX_PORT0_DIR: reg_decode = IEC_R_DIR;
                `IEC_IDX_PORT0_LATCH: reg_decode = IEC_R_LATCH;
                default: reg_decode = IEC_R_NONE;
            endcase
        end
    endfunction

    assign sel = reg_decode(avs_address);
    assign req = avs_read || avs_write;
    assign wr_go = avs_write && !wait_r;

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign timer_output_pin = tout_r;
    assign match_irq_zero = irq0_r;
    assign match_irq_one = irq1_r;
    assign port0_out = p0_out_r;
    assign port0_oe = p0_oe_r;

    ////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then waitrequest low for one edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !(req && wait_r);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            unique case (sel)
                IEC_R_COUNT: rdata_r <= {16'h0000, up_counter_r}; // R12
                IEC_R_CMP0: rdata_r <= {16'h0000, compare_reg_zero_r};
                IEC_R_CMP1: rdata_r <= {16'h0000, compare_reg_one_r};
                IEC_R_MODE: rdata_r <= {24'h000000, timer_mode_register_r};
                IEC_R_PRESC: rdata_r <= {24'h000000, prescaler_register_r};
                IEC_R_OUTCTL: begin
                    // set and clear triggers always read as zero
                    rdata_r <= {24'h000000, output_control_register_r};
                end
                IEC_R_ROUTE: rdata_r <= {24'h000000, pin_routing_select_r};
                IEC_R_DIR: rdata_r <= {24'h000000, port0_direction_r};
                IEC_R_LATCH: rdata_r <= {24'h000000, port0_latch_r};
                IEC_R_NONE: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            compare_reg_zero_r <= `IEC_RST_COUNT;
            compare_reg_one_r <= `IEC_RST_COUNT;
            timer_mode_register_r <= `IEC_RST_BYTE;
            prescaler_register_r <= `IEC_RST_BYTE;
            output_control_register_r <= `IEC_RST_BYTE;
            pin_routing_select_r <= `IEC_RST_ROUTE;
            port0_direction_r <= `IEC_RST_PORT0_DIR; // R15
            port0_latch_r <= `IEC_RST_BYTE;
        end else if (wr_go) begin
            unique case (sel)
                IEC_R_CMP0: begin
                    if (avs_byteenable[0]) begin
                        compare_reg_zero_r[7:0] <= avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        compare_reg_zero_r[15:8] <= avs_writedata[15:8];
                    end
                end
                IEC_R_CMP1: begin
                    if (avs_byteenable[0]) begin
                        compare_reg_one_r[7:0] <= avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        compare_reg_one_r[15:8] <= avs_writedata[15:8];
                    end
                end
                IEC_R_MODE: begin
                    if (avs_byteenable[0]) begin
                        timer_mode_register_r <= avs_writedata[7:0];
                    end
                end
                IEC_R_PRESC: begin
                    if (avs_byteenable[0]) begin
                        prescaler_register_r <= avs_writedata[7:0];
                    end
                end
                IEC_R_OUTCTL: begin
                    if (avs_byteenable[0]) begin
                        output_control_register_r <= avs_writedata[7:0]
                            & ~((8'h01 << `IEC_OC_CLR)
                            | (8'h01 << `IEC_OC_SET));
                    end
                end
                IEC_R_ROUTE: begin
                    if (avs_byteenable[0]) begin
                        pin_routing_select_r <= avs_writedata[7:0];
                    end
                end
                IEC_R_DIR: begin
                    if (avs_byteenable[0]) begin
                        port0_direction_r <= avs_writedata[7:0];
                    end
                end
                IEC_R_LATCH: begin
                    if (avs_byteenable[0]) begin
                        port0_latch_r <= avs_writedata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event input routing and filtering
    assign route_sel = pin_routing_select_r[`IEC_RT_HI:`IEC_RT_LO];

    always_comb begin
        unique case (route_sel)
            `IEC_RT_PIN_A: event_in = alt_pin_a; // R13
            `IEC_RT_PIN_B: event_in = alt_pin_b; // R13
            default: event_in = 1'b0; // R13
        endcase
    end

    iec_edge_filter u_filter (
        .clock(clock),
        .reset(reset),
        .pin(event_in),
        .edge_sel(prescaler_register_r[`IEC_ES0_HI:`IEC_ES0_LO]),
        .edge_pulse(event_edge)
    );

    ////////////////////////////////////////////////////////////////////
    // count clock
    assign mode_sel = timer_mode_register_r[`IEC_MODE_HI:`IEC_MODE_LO];
    assign clk_sel = prescaler_register_r[`IEC_CKS_HI:`IEC_CKS_LO];
    assign running = mode_sel != `IEC_MODE_STOP;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_r <= '0;
        end else if (!running) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_comb begin
        unique case (clk_sel)
            `IEC_CKS_FULL: tick = 1'b1;
            `IEC_CKS_DIV4: tick = &div_r[`IEC_DIV4_BIT:0];
            `IEC_CKS_DIV256: tick = &div_r[`IEC_DIV256_BIT:0];
            `IEC_CKS_EVENT: tick = event_edge; // R08
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // counter and compare
    assign match0 = running && started_r && tick
        && (up_counter_r == compare_reg_zero_r); // R02 R21
    assign match1 = running && started_r && tick
        && (up_counter_r == compare_reg_one_r); // R05 R21

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            up_counter_r <= `IEC_RST_COUNT;
            started_r <= 1'b0;
        end else if (!running) begin
            up_counter_r <= `IEC_RST_COUNT; // R21
            started_r <= 1'b0;
        end else if (tick) begin
            // the first count clock only synchronises the start
            started_r <= 1'b1; // R10
            if (!started_r) begin
                up_counter_r <= `IEC_RST_COUNT; // R10
            end else if (mode_sel == `IEC_MODE_MATCH_CLEAR && match0) begin
                up_counter_r <= `IEC_RST_COUNT; // R01 R02 R03 R07
            end else begin
                up_counter_r <= up_counter_r + 1'b1; // R20
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq0_r <= 1'b0;
            irq1_r <= 1'b0;
        end else begin
            irq0_r <= match0; // R02 R07
            irq1_r <= match1; // R05
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timer output
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tout_r <= 1'b0;
        end else if (!output_control_register_r[`IEC_OC_ENABLE]) begin
            tout_r <= 1'b0; // R19
        end else if (wr_go && sel == IEC_R_OUTCTL && avs_byteenable[0]
            && avs_writedata[`IEC_OC_CLR]) begin
            tout_r <= 1'b0;
        end else if (wr_go && sel == IEC_R_OUTCTL && avs_byteenable[0]
            && avs_writedata[`IEC_OC_SET]) begin
            tout_r <= 1'b1;
        end else if ((match0 && output_control_register_r[`IEC_OC_INV0])
            ^ (match1 && output_control_register_r[`IEC_OC_INV1])) begin
            tout_r <= !tout_r; // R06 R07 R19
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port 0 pins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            p0_out_r <= `IEC_RST_BYTE;
            p0_oe_r <= `IEC_RST_BYTE;
        end else begin
            p0_out_r <= port0_latch_r
                | (iec_byte_t'(tout_r) << `IEC_TOUT_PIN); // R16
            p0_oe_r <= ~port0_direction_r; // R14 R17
        end
    end
endmodule
`default_nettype wire
